/* core/async_timer_clock_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module async_timer_clock_sync (
  // Clock and reset
  input wire logic CLK_SYS_I,
  input wire logic NRST_I,
  // Avalon-MM slave
  input wire async_timer_pkg::bus_req_s AVS_REQ_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  // Oscillator pins
  input wire logic OSC_INPUT_PIN_I,
  output logic OSC_PINS_CLAIMED_O,
  output logic OSC_ENABLE_O,
  // Compare outputs, interrupt, wake
  output logic OUT_A_O,
  output logic OUT_B_O,
  output logic IRQ_O,
  output logic WAKE_O
);
  import async_timer_pkg::*;

  //////////////////////////////////////////////////////////////////////
  // Bus slave: one wait cycle then answer
  logic wait_q;
  logic [7:0] hold_q [NUM_HOLD];
  logic [7:0] dest_q [NUM_HOLD];
  logic [NUM_HOLD-1:0] busy_q;
  logic async_sel_q;
  logic [2:0] flags_q;
  logic [2:0] irq_en_q;
  logic [1:0] sleep_q;
  logic [7:0] shadow_q;
  logic [7:0] count_q;
  logic [31:0] rdata_q;
  logic req;
  logic wr;
  assign req = AVS_REQ_I.read | AVS_REQ_I.write;
  // Write lands at the edge where waitrequest is seen low
  assign wr = AVS_REQ_I.write & ~wait_q;

  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= ~(req & wait_q);
    end
  end

  function automatic int hold_index(input logic [7:0] a);
    case (a)
      ADDR_CTRL_A: hold_index = HOLD_CTRL_A;
      ADDR_CTRL_B: hold_index = HOLD_CTRL_B;
      ADDR_COUNT: hold_index = HOLD_COUNT;
      ADDR_CMP_A: hold_index = HOLD_CMP_A;
      ADDR_CMP_B: hold_index = HOLD_CMP_B;
      default: hold_index = NUM_HOLD;
    endcase
  endfunction : hold_index

  //////////////////////////////////////////////////////////////////////
  // Oscillator synchroniser and edge detect
  logic [2:0] osc_sync_q;
  logic osc_rise;
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      osc_sync_q <= 3'b000;
    end else begin
      osc_sync_q <= {osc_sync_q[1:0], OSC_INPUT_PIN_I};
    end
  end
  assign osc_rise = osc_sync_q[1] & ~osc_sync_q[2];

  // Source tick: every cycle, or osc rise when async
  logic src_tick;
  assign src_tick = async_sel_q ? osc_rise : 1'b1;

  //////////////////////////////////////////////////////////////////////
  // Holding registers and transfer counters
  logic [1:0] edge_cnt_q [NUM_HOLD];
  logic [NUM_HOLD-1:0] xfer;
  always_comb begin
    for (int i = 0; i < NUM_HOLD; i++) begin
      xfer[i] = busy_q[i] & osc_rise & (32'(edge_cnt_q[i]) == XFER_EDGES - 1);
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      for (int i = 0; i < NUM_HOLD; i++) begin
        hold_q[i] <= RESET_VAL;
        busy_q[i] <= 1'b0;
        edge_cnt_q[i] <= 2'd0;
      end
    end else begin
      for (int i = 0; i < NUM_HOLD; i++) begin
        if (wr && hold_index(AVS_REQ_I.address) == i && async_sel_q) begin
          hold_q[i] <= AVS_REQ_I.writedata[7:0];
          busy_q[i] <= 1'b1;
          edge_cnt_q[i] <= 2'd0;
        end else if (xfer[i]) begin
          busy_q[i] <= 1'b0;
        end else if (busy_q[i] && osc_rise) begin
          edge_cnt_q[i] <= edge_cnt_q[i] + 2'd1;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Destination registers and counter
  logic [7:0] psc_cnt_q;
  logic [9:0] div_q;
  logic tick;
  logic [7:0] top;
  logic cmp_block;
  logic match_a;
  logic match_b;
  logic psr_wr;
  assign psr_wr = wr && AVS_REQ_I.address == ADDR_GEN_CTRL && AVS_REQ_I.writedata[GEN_PSR_BIT];

  function automatic logic [7:0] dest_mask(input int i);
    dest_mask = (i == HOLD_CTRL_A) ? CTRL_A_MASK : (i == HOLD_CTRL_B) ? CTRL_B_MASK : 8'hff;
  endfunction : dest_mask

  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      for (int i = 0; i < NUM_HOLD; i++) begin
        dest_q[i] <= RESET_VAL;
      end
    end else begin
      for (int i = 0; i < NUM_HOLD; i++) begin
        if (wr && hold_index(AVS_REQ_I.address) == i && !async_sel_q) begin
          dest_q[i] <= AVS_REQ_I.writedata[7:0] & dest_mask(i);
        end else if (xfer[i]) begin
          dest_q[i] <= hold_q[i] & dest_mask(i);
        end
      end
    end
  end

  // Prescaler
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      div_q <= 10'd0;
    end else if (psr_wr) begin
      div_q <= 10'd0;
    end else if (src_tick) begin
      div_q <= div_q + 10'd1;
    end
  end

  always_comb begin
    case (dest_q[HOLD_CTRL_B][2:0])
      3'd0: tick = 1'b0;
      3'd1: tick = src_tick;
      3'd2: tick = src_tick & (div_q[2:0] == 3'h7);
      3'd3: tick = src_tick & (div_q[4:0] == 5'h1f);
      3'd4: tick = src_tick & (div_q[5:0] == 6'h3f);
      3'd5: tick = src_tick & (div_q[6:0] == 7'h7f);
      3'd6: tick = src_tick & (div_q[7:0] == 8'hff);
      default: tick = src_tick & (div_q == 10'h3ff);
    endcase
  end

  assign top = dest_q[HOLD_CTRL_A][1] ? dest_q[HOLD_CMP_A] : 8'hff;
  assign cmp_block = async_sel_q & (busy_q[HOLD_CMP_A] | busy_q[HOLD_CMP_B] | busy_q[HOLD_COUNT]);
  assign match_a = tick & ~cmp_block & (count_q == dest_q[HOLD_CMP_A]);
  assign match_b = tick & ~cmp_block & (count_q == dest_q[HOLD_CMP_B]);

  // Counter: written value loads, else counts on tick
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      count_q <= RESET_VAL;
    end else if (xfer[HOLD_COUNT]) begin
      count_q <= hold_q[HOLD_COUNT];
    end else if (wr && AVS_REQ_I.address == ADDR_COUNT && !async_sel_q) begin
      count_q <= AVS_REQ_I.writedata[7:0];
    end else if (tick) begin
      count_q <= (count_q == top) ? 8'h00 : count_q + 8'h01;
    end
  end

  // Shadow for reads, refreshed every cycle, or on osc rise when async
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      shadow_q <= RESET_VAL;
    end else if (!async_sel_q || osc_rise) begin
      shadow_q <= count_q;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Compare outputs change on timer tick directly
  function automatic logic out_next(input logic cur, input logic [1:0] mode, input logic m);
    case (mode)
      2'b01: out_next = m ? ~cur : cur;
      2'b10: out_next = m ? 1'b0 : cur;
      2'b11: out_next = m ? 1'b1 : cur;
      default: out_next = cur;
    endcase
  endfunction : out_next

  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      OUT_A_O <= 1'b0;
      OUT_B_O <= 1'b0;
    end else begin
      OUT_A_O <= out_next(OUT_A_O, dest_q[HOLD_CTRL_A][7:6], match_a);
      OUT_B_O <= out_next(OUT_B_O, dest_q[HOLD_CTRL_A][5:4], match_b);
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Event flags: async events delayed three cycles
  logic [2:0] evt;
  logic [2:0] evt_pipe_q [FLAG_SYNC_STAGES];
  logic [2:0] evt_dly;
  assign evt = {match_b, match_a, tick & (count_q == top)};
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      for (int i = 0; i < FLAG_SYNC_STAGES; i++) begin
        evt_pipe_q[i] <= 3'b000;
      end
    end else begin
      evt_pipe_q[0] <= evt;
      for (int i = 1; i < FLAG_SYNC_STAGES; i++) begin
        evt_pipe_q[i] <= evt_pipe_q[i-1];
      end
    end
  end
  assign evt_dly = async_sel_q ? evt_pipe_q[FLAG_SYNC_STAGES-1] : evt;

  logic flag_clr;
  assign flag_clr = wr && AVS_REQ_I.address == ADDR_FLAGS;
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      flags_q <= 3'b000;
    end else begin
      flags_q <= (flags_q & ~(flag_clr ? AVS_REQ_I.writedata[2:0] : 3'b000)) | evt_dly;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Control bits: async select, irq enables, sleep mode
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      async_sel_q <= 1'b0;
      irq_en_q <= 3'b000;
      sleep_q <= SLEEP_NONE;
    end else if (wr) begin
      if (AVS_REQ_I.address == ADDR_ASYNC_STATUS) begin
        async_sel_q <= AVS_REQ_I.writedata[STATUS_ASYNC_BIT];
      end
      if (AVS_REQ_I.address == ADDR_GEN_CTRL) begin
        irq_en_q <= AVS_REQ_I.writedata[6:4];
      end
      if (AVS_REQ_I.address == ADDR_SLEEP) begin
        sleep_q <= AVS_REQ_I.writedata[1:0];
      end
    end
  end

  // Wake on next source tick after a pending flag; re-raised while pending
  logic irq_lvl;
  logic wake_arm_q;
  assign irq_lvl = |(flags_q & irq_en_q);
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      wake_arm_q <= 1'b0;
      WAKE_O <= 1'b0;
      IRQ_O <= 1'b0;
      OSC_ENABLE_O <= 1'b0;
      OSC_PINS_CLAIMED_O <= 1'b0;
    end else begin
      wake_arm_q <= irq_lvl & (sleep_q == SLEEP_SAVE);
      WAKE_O <= wake_arm_q & irq_lvl & (sleep_q == SLEEP_SAVE) & src_tick;
      IRQ_O <= irq_lvl;
      OSC_ENABLE_O <= async_sel_q & (sleep_q != SLEEP_POWERDOWN);
      OSC_PINS_CLAIMED_O <= async_sel_q;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Read mux
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      case (AVS_REQ_I.address)
        ADDR_CTRL_A: rdata_q <= {24'h000000, dest_q[HOLD_CTRL_A]};
        ADDR_CTRL_B: rdata_q <= {24'h000000, dest_q[HOLD_CTRL_B]};
        ADDR_COUNT: rdata_q <= {24'h000000, shadow_q};
        ADDR_CMP_A: rdata_q <= {24'h000000, dest_q[HOLD_CMP_A]};
        ADDR_CMP_B: rdata_q <= {24'h000000, dest_q[HOLD_CMP_B]};
        ADDR_ASYNC_STATUS: rdata_q <= {26'h0, async_sel_q, busy_q};
        ADDR_FLAGS: rdata_q <= {29'h0, flags_q};
        ADDR_GEN_CTRL: rdata_q <= {25'h0, irq_en_q, 4'h0};
        ADDR_SLEEP: rdata_q <= {30'h0, sleep_q};
        default: rdata_q <= 32'h0000_0000;
      endcase
    end
  end
  assign AVS_READDATA_O = rdata_q;
  assign AVS_WAITREQUEST_O = wait_q;
endmodule : async_timer_clock_sync
`default_nettype wire

/* common/async_timer_pkg.sv */
//
// Contract
// - Sync: prescaled tick enables I/O clock
// - Writes land in holding, two osc edges
// - Five independent holding registers
// - Status register shows busy per holding
// - Compare match suppressed while count or compare write pending
// - Re-sleep within osc cycle re-raises interrupt
// - Oscillator runs when async selected, except power-down
// - Registers undefined after power-down wake
// - Wake starts on next source tick
// - Counter read via shadow, osc refreshed
// - Flags three cycles plus timer cycle
// - Default I/O clock, select claims pins
// - Prescaler stop, 1, 8..1024
// - Prescaler reset bit restarts phase
// - Control A layout, reset zero
package async_timer_pkg;
  localparam logic [7:0] ADDR_CTRL_A = 8'hb0;
  localparam logic [7:0] ADDR_CTRL_B = 8'hb1;
  localparam logic [7:0] ADDR_COUNT = 8'hb2;
  localparam logic [7:0] ADDR_CMP_A = 8'hb3;
  localparam logic [7:0] ADDR_CMP_B = 8'hb4;
  localparam logic [7:0] ADDR_ASYNC_STATUS = 8'hb6;
  localparam logic [7:0] ADDR_FLAGS = 8'hb7;
  localparam logic [7:0] ADDR_GEN_CTRL = 8'hb8;
  localparam logic [7:0] ADDR_SLEEP = 8'hb9;
  localparam logic [7:0] CTRL_A_MASK = 8'hf3;
  localparam logic [7:0] CTRL_B_MASK = 8'h07;
  localparam logic [7:0] RESET_VAL = 8'h00;
  localparam int STATUS_ASYNC_BIT = 5;
  localparam int GEN_PSR_BIT = 1;
  localparam int FLAG_OVF_BIT = 0;
  localparam int FLAG_CMPA_BIT = 1;
  localparam int FLAG_CMPB_BIT = 2;
  localparam int HOLD_CTRL_A = 0;
  localparam int HOLD_CTRL_B = 1;
  localparam int HOLD_COUNT = 2;
  localparam int HOLD_CMP_A = 3;
  localparam int HOLD_CMP_B = 4;
  localparam int NUM_HOLD = 5;
  localparam int XFER_EDGES = 2;
  localparam int FLAG_SYNC_STAGES = 3;
  typedef enum logic [1:0] {
    SLEEP_NONE, SLEEP_SAVE, SLEEP_POWERDOWN
  } sleep_mode_e;
  typedef struct packed {
    logic [7:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } bus_req_s;
endpackage : async_timer_pkg

/* tb/async_timer_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module async_timer_chk (
  // Clock and reset
  input wire logic CLK_SYS_I,
  input wire logic NRST_I,
  // Register bus
  input wire async_timer_pkg::bus_req_s AVS_REQ_I,
  input wire logic [31:0] AVS_READDATA_O,
  input wire logic AVS_WAITREQUEST_O,
  // Oscillator and outputs
  input wire logic OSC_INPUT_PIN_I,
  input wire logic OSC_PINS_CLAIMED_O,
  input wire logic OSC_ENABLE_O,
  input wire logic OUT_A_O,
  input wire logic OUT_B_O,
  input wire logic IRQ_O,
  input wire logic WAKE_O
);
  import async_timer_pkg::*;
  logic req;
  assign req = AVS_REQ_I.read | AVS_REQ_I.write;
  default clocking @(posedge CLK_SYS_I);
  endclocking
  default disable iff (!NRST_I);
  ////////////////////////////////
  reset_idle_a: assert property ($rose(NRST_I) |-> AVS_WAITREQUEST_O && !IRQ_O && !WAKE_O && !OSC_ENABLE_O)
    else $error("outputs not idle after reset");
  ack_next_a: assert property (req && AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O)
    else $error("request not answered next cycle");
  ack_single_a: assert property (!AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O)
    else $error("answer longer than one cycle");
  no_spurious_a: assert property (!req && AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O)
    else $error("answer without request");
  upper_zero_a: assert property (!AVS_WAITREQUEST_O |-> AVS_READDATA_O[31:8] == 24'h0)
    else $error("upper read bytes not zero");
  osc_claim_a: assert property (OSC_ENABLE_O |-> OSC_PINS_CLAIMED_O || $past(OSC_PINS_CLAIMED_O))
    else $error("oscillator enabled without async select");
  claim_cause_a: assert property ($changed(OSC_PINS_CLAIMED_O) |-> $past(AVS_REQ_I.write) || $past(AVS_REQ_I.write, 2))
    else $error("pin claim changed without write");
  wake_pulse_a: assert property (WAKE_O |=> !WAKE_O)
    else $error("wake longer than one cycle");
  cover property (AVS_REQ_I.write && !AVS_WAITREQUEST_O);
  cover property ($rose(OSC_PINS_CLAIMED_O));
  cover property (WAKE_O && IRQ_O);
endmodule : async_timer_chk
bind async_timer_clock_sync async_timer_chk i_chk (.CLK_SYS_I, .NRST_I, .AVS_REQ_I, .AVS_READDATA_O,
  .AVS_WAITREQUEST_O, .OSC_INPUT_PIN_I, .OSC_PINS_CLAIMED_O, .OSC_ENABLE_O, .OUT_A_O, .OUT_B_O, .IRQ_O, .WAKE_O);
`default_nettype wire

/* tb/osc_crystal_model.sv */
`timescale 1ns/1ps
`default_nettype none
module osc_crystal_model #(
  parameter int HALF_NS = 61
) (
  // Run request and oscillator pin
  input wire logic run_i,
  output logic osc_o
);
  // Toggles while running, stands low while stopped
  initial osc_o = 1'b0;
  always begin
    #(HALF_NS);
    osc_o = run_i ? ~osc_o : 1'b0;
  end
endmodule : osc_crystal_model
`default_nettype wire

/* tb/async_timer_clock_sync_test.sv */
`timescale 1ns/1ps
`default_nettype none
module async_timer_clock_sync_test;
  import async_timer_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  bus_req_s req = '0;
  logic [31:0] rdata;
  logic [31:0] r;
  logic wreq, claimed, osc_en, out_a, out_b, irq, wake, osc;
  int n_fail = 0;
  int n_checks = 0;
  int n;
  always #4 clk = ~clk;
  osc_crystal_model #(.HALF_NS(61)) i_osc (.run_i(osc_en), .osc_o(osc));
  async_timer_clock_sync i_dut (.CLK_SYS_I(clk), .NRST_I(nrst), .AVS_REQ_I(req), .AVS_READDATA_O(rdata),
    .AVS_WAITREQUEST_O(wreq), .OSC_INPUT_PIN_I(osc), .OSC_PINS_CLAIMED_O(claimed), .OSC_ENABLE_O(osc_en),
    .OUT_A_O(out_a), .OUT_B_O(out_b), .IRQ_O(irq), .WAKE_O(wake));
  ////////////////////////////////
  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] exp, input logic [31:0] got, input string nm);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // Holds the request until waitrequest is sampled low
  task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
    int k;
    k = 0;
    req <= '{address: a, read: !w, write: w, writedata: {24'h0, d}};
    @(posedge clk);
    while (wreq !== 1'b0 && k < 50) begin
      @(posedge clk);
      k++;
    end
    if (k == 50)
      n_fail++;
    r = rdata;
    req <= '0;
    @(posedge clk);
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(a, 1'b1, d);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string nm);
    bus(a, 1'b0, 8'h0);
    chk(exp, r, nm);
  endtask : rdc
  task automatic wait_idle;
    int k;
    k = 0;
    bus(ADDR_ASYNC_STATUS, 1'b0, 8'h0);
    while (r[4:0] !== 5'h0 && k < 100) begin
      bus(ADDR_ASYNC_STATUS, 1'b0, 8'h0);
      k++;
    end
    if (k == 100)
      n_fail++;
  endtask : wait_idle
  ////////////////////////////////
  initial begin
    #300000;
    n_fail++;
    stop_test();
  end
  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rdc(ADDR_CTRL_A, 32'h0, "ctrl_a reset");
    rdc(ADDR_ASYNC_STATUS, 32'h0, "status reset");
    chk(32'h0, {31'h0, claimed}, "pins claimed");
    wr(ADDR_CTRL_A, 8'hff);
    rdc(ADDR_CTRL_A, {24'h0, CTRL_A_MASK}, "ctrl_a fields");
    wr(8'hb5, 8'hff);
    rdc(8'hb5, 32'h0, "unmapped");
    for (int s = 0; s < 8; s++) begin
      wr(ADDR_CTRL_B, 8'(s));
      rdc(ADDR_CTRL_B, 32'(s), "prescale select");
    end
    chk(32'h3, {30'h0, out_b, out_a}, "compare outputs");
    wr(ADDR_CTRL_A, 8'h00);
    wr(ADDR_CTRL_B, 8'h02);
    wr(ADDR_GEN_CTRL, 8'h02);
    wr(ADDR_COUNT, 8'h00);
    repeat (33) @(posedge clk);
    rdc(ADDR_COUNT, 32'h4, "prescale by 8");
    wr(ADDR_CTRL_B, 8'h01);
    wr(ADDR_ASYNC_STATUS, 8'h20);
    repeat (2) @(posedge osc);
    @(posedge clk);
    chk(32'h1, {31'h0, claimed}, "pins claimed");
    wr(ADDR_CMP_A, 8'h3c);
    wr(ADDR_COUNT, 8'h10);
    rdc(ADDR_ASYNC_STATUS, 32'h2c, "busy flags");
    wait_idle();
    rdc(ADDR_CMP_A, 32'h3c, "cmp_a moved");
    wr(ADDR_CTRL_B, 8'h00);
    wait_idle();
    wr(ADDR_COUNT, 8'h55);
    wait_idle();
    wr(ADDR_CTRL_B, 8'h00);
    wait_idle();
    rdc(ADDR_COUNT, 32'h55, "count stopped");
    wr(ADDR_CTRL_B, 8'h01);
    wait_idle();
    repeat (100) @(posedge clk);
    bus(ADDR_COUNT, 1'b0, 8'h0);
    chk(32'h1, {31'h0, r[7:0] !== 8'h55}, "count runs");
    wr(ADDR_FLAGS, 8'h07);
    wr(ADDR_GEN_CTRL, 8'h10);
    wr(ADDR_COUNT, 8'hfd);
    wait_idle();
    wr(ADDR_SLEEP, 8'h01);
    n = 0;
    while (wake !== 1'b1 && n < 300) begin
      @(posedge clk);
      n++;
    end
    chk(32'h1, {31'h0, wake}, "wake");
    chk(32'h1, {31'h0, irq}, "irq");
    wr(ADDR_SLEEP, 8'h00);
    wr(ADDR_FLAGS, 8'h07);
    wr(ADDR_GEN_CTRL, 8'h00);
    @(posedge clk);
    chk(32'h0, {31'h0, irq}, "irq off");
    wr(ADDR_CMP_B, 8'h00);
    wait_idle();
    wr(ADDR_SLEEP, 8'h02);
    @(posedge clk);
    chk(32'h0, {31'h0, osc_en}, "osc power-down");
    wr(ADDR_SLEEP, 8'h00);
    @(posedge clk);
    chk(32'h1, {31'h0, osc_en}, "osc running");
    stop_test();
  end
endmodule : async_timer_clock_sync_test
`default_nettype wire
